// ---- errfi_pkg.sv ----
// Purpose : Shared constants and types for the error record and fault
//           injection node.
// Assumes : One core clock; register access by system-register alias.
// Notes   : Every field position, code and reset value lives here.
package errfi_pkg;

	// Data width of every register alias
	localparam int unsigned DW = 32;
	// Width of the record-select value
	localparam int unsigned SEL_W = 16;
	// Record-select value that exposes this node's record
	localparam logic [SEL_W-1:0] SEL_RECORD0 = 16'h0000;

	// Capability word of the fault generation feature register
	localparam logic [DW-1:0] FEAT_VALUE = 32'hC0000062;
	// Capability bit positions
	localparam int unsigned FT_RESTART = 30;
	localparam int unsigned FT_CE_HI   = 7;
	localparam int unsigned FT_CE_LO   = 6;
	localparam int unsigned FT_DE      = 5;
	localparam int unsigned FT_LATENT  = 4;
	localparam int unsigned FT_RECOV   = 3;
	localparam int unsigned FT_UNRECOV = 2;
	localparam int unsigned FT_UNCONT  = 1;

	// Primary status bit positions
	localparam int unsigned ST_AV    = 31;
	localparam int unsigned ST_V     = 30;
	localparam int unsigned ST_UE    = 29;
	localparam int unsigned ST_ER    = 28;
	localparam int unsigned ST_OF    = 27;
	localparam int unsigned ST_MV    = 26;
	localparam int unsigned ST_CE_HI = 25;
	localparam int unsigned ST_CE_LO = 24;
	localparam int unsigned ST_DE    = 23;
	localparam int unsigned ST_PN    = 22;
	localparam int unsigned ST_UET_HI = 21;
	localparam int unsigned ST_UET_LO = 20;
	localparam int unsigned ST_CODE_HI = 4;
	localparam int unsigned ST_CODE_LO = 0;

	// Field encodings
	localparam logic [1:0] CE_NONE  = 2'h0;
	localparam logic [1:0] CE_SOME  = 2'h2;
	localparam logic [1:0] UET_UNCONT = 2'h0;
	localparam logic       PN_VALUE = 1'b0;
	localparam logic [DW-1:0] STATUS_RESET = 32'h00000000;
	localparam logic [DW-1:0] WORD_ZERO    = 32'h00000000;

	// Primary error codes
	localparam logic [4:0] CODE_NONE     = 5'h00;
	localparam logic [4:0] CODE_IMPL     = 5'h01;
	localparam logic [4:0] CODE_BUF_ECC  = 5'h02;
	localparam logic [4:0] CODE_INJ_TAG  = 5'h05;
	localparam logic [4:0] CODE_DATA_ECC = 5'h06;
	localparam logic [4:0] CODE_TAG_ECC  = 5'h07;
	localparam logic [4:0] CODE_TLB_PAR  = 5'h08;
	localparam logic [4:0] CODE_COPYBACK = 5'h12;
	localparam logic [4:0] CODE_NO_DEFER = 5'h15;

	// Implementation error code placed in misc0 on injection (arbitrary)
	localparam logic [7:0] INJ_IMPL_CODE = 8'h01;
	// Injection never raises the critical mark in this node
	localparam logic       INJ_SETS_CRIT = 1'b0;

	// Error classes, lowest priority first
	typedef enum logic [1:0] {
		ERRFI_CLS_CE,
		ERRFI_CLS_DE,
		ERRFI_CLS_UE
	} errfi_class_t;

	// Register aliases reachable through record selection
	typedef enum logic [1:0] {
		ERRFI_REG_FEAT,
		ERRFI_REG_STAT,
		ERRFI_REG_ADDR,
		ERRFI_REG_MISC0
	} errfi_reg_t;

endpackage : errfi_pkg

// ---- errfi_merge.sv ----
// Purpose : Folds one error event into the primary status flags.
// Assumes : Inputs are the flags after any software clear this cycle.
// Notes   : Pure combinational; priority is UE over DE over CE.
`timescale 1ns/1ns
module errfi_merge
	import errfi_pkg::*;
(
	input  wire logic         i_ev,        // Event this cycle
	input  wire errfi_class_t i_ev_class,  // Class of the event
	input  wire logic         i_ev_av,     // Event carries an address
	input  wire logic         i_ev_keep_av,// Leave address state alone
	input  wire logic         i_ev_mv,     // Event carries misc syndrome
	input  wire logic         i_ev_abort,  // Abort reported to requester
	input  wire logic         i_v,         // Current flags
	input  wire logic         i_ue,
	input  wire logic         i_de,
	input  wire logic [1:0]   i_ce,
	input  wire logic         i_of,
	input  wire logic         i_er,
	input  wire logic         i_av,
	input  wire logic         i_mv,
	output logic              o_v,         // Next flags
	output logic              o_ue,
	output logic              o_de,
	output logic [1:0]        o_ce,
	output logic              o_of,
	output logic              o_er,
	output logic              o_av,
	output logic              o_mv,
	output logic              o_take       // Event owns the syndrome
);
	logic [1:0] cur_rank; // Rank of the highest class already held
	logic [1:0] new_rank; // Rank of the incoming event
	logic       held;     // Some class already held

	// Rank and replacement decision
	always_comb begin
		held     = i_ue | i_de | (i_ce != CE_NONE);
		cur_rank = i_ue ? 2'(ERRFI_CLS_UE) :
			i_de ? 2'(ERRFI_CLS_DE) : 2'(ERRFI_CLS_CE);
		new_rank = 2'(i_ev_class);
		// Higher class replaces the syndrome so it always
		// describes the highest-priority error
		o_take   = i_ev & (!i_v | !held | (new_rank > cur_rank));
	end

	// Next flag values
	always_comb begin
		o_v  = i_v | i_ev;
		o_ue = i_ue | (i_ev & (i_ev_class == ERRFI_CLS_UE));
		o_de = i_de | (i_ev & (i_ev_class == ERRFI_CLS_DE));
		o_ce = (i_ev & (i_ev_class == ERRFI_CLS_CE)) ? CE_SOME : i_ce;
		o_er = i_er | (i_ev & i_ev_abort);
		o_of = i_of;
		o_av = i_av;
		o_mv = i_mv;
		if (o_take) begin
			// New highest class: overflow restarts for it
			o_of = 1'b0;
			o_mv = i_ev_mv;
			if (!i_ev_keep_av) begin
				o_av = i_ev_av;
			end
		end else if (i_ev && i_v && held && new_rank == cur_rank) begin
			// Same class again: its details are dropped
			o_of = 1'b1;
		end
	end

endmodule : errfi_merge

// ---- errfi_node.sv ----
// Purpose : Error record node with pseudo fault injection recording.
// Assumes : i_ref_clk at 100 MHz; inputs synchronous to it; system
//           register aliases driven by the core one access a cycle.
// Notes   : Outputs are all flip-flops; read data lands one cycle late.
//
// Overview of operation
// - Feature register is fixed read-only capabilities
// - Feature bit 30 reports restart option set
// - Injection loads chosen primary and impl codes
// - Injected misc syndrome sets misc-valid flag
// - Injection always leaves address alone
// - Injection clears poison flag to zero
// - Injection sets abort flag like real errors
// - Injection critical mark is fixed by design
// - Corrected, deferred, uncontainable generation controllable
// - Latent, recoverable, unrecoverable generation unsupported
// - Injection updates overflow like real errors
// - Address valid means highest-priority error address, unless an injection took over
// - Record valid once any error recorded
// - Uncorrected flag holds recovery interrupt until cleared
// - Abort flag set when abort signalled
// - Overflow set when same-class details discarded
// - Misc valid marks misc registers meaningful
// - Corrected field reads 00 or 10
// - Deferred flag set on poisoned deferral
// - Poison reads 0, type reads uncontainable
// - Primary code uses the documented encodings
// - Injected codes are 0x5 tag, 0x6 data
// - Record reachable only when select is zero
`timescale 1ns/1ns
module errfi_node (
	input  wire logic                    i_ref_clk,   // Core clock
	input  wire logic                    i_arst_n,    // Async reset
	// System register alias access
	input  wire logic [errfi_pkg::SEL_W-1:0] i_record_select,
	input  wire errfi_pkg::errfi_reg_t   i_reg_id,    // Alias picked
	input  wire logic                    i_reg_rd,    // Read strobe
	input  wire logic                    i_reg_wr,    // Write strobe
	input  wire logic [errfi_pkg::DW-1:0] i_reg_wdata, // Write data
	output logic [errfi_pkg::DW-1:0]     o_reg_rdata, // Read data
	output logic                         o_reg_rack,  // Read done
	// Naturally detected errors
	input  wire logic                    i_err_valid, // Error pulse
	input  wire errfi_pkg::errfi_class_t i_err_class, // Its class
	input  wire logic [4:0]              i_err_code,  // Primary code
	input  wire logic                    i_err_abort, // Abort signalled
	input  wire logic                    i_err_av,    // Address known
	input  wire logic [errfi_pkg::DW-1:0] i_err_addr, // Access address
	input  wire logic                    i_err_mv,    // Misc present
	input  wire logic [errfi_pkg::DW-1:0] i_err_misc, // Misc syndrome
	// Injection counter expiry with an enabled type
	input  wire logic                    i_inj_fire,  // Expiry pulse
	input  wire errfi_pkg::errfi_class_t i_inj_class, // Enabled type
	input  wire logic                    i_inj_tag,   // Tag, else data
	input  wire logic                    i_inj_abort, // Abort signalled
	// Recovery interrupt
	input  wire logic                    i_recovery_irq_en, // Enable
	output logic                         o_recovery_irq,    // Level
	output logic                         o_inj_crit         // Crit mark
);
	import errfi_pkg::*;

	// Reset synchroniser
	logic rst_meta_r;  // First stage, read only by the second
	logic rst_n_r;     // Released reset used by the design

	// Primary status state
	logic       av_r;       // Address valid
	logic       v_r;        // Record valid
	logic       ue_r;       // Uncorrected
	logic       er_r;       // Abort reported
	logic       of_r;       // Overflow
	logic       mv_r;       // Misc valid
	logic [1:0] ce_r;       // Corrected field
	logic       de_r;       // Deferred
	logic [4:0] code_r;     // Primary error code
	logic [DW-1:0] addr_r;  // Address register
	logic [DW-1:0] misc0_r; // First misc register
	logic       crit_r;     // Critical mark of injection

	// Combined event after muxing natural and injected sources
	logic         ev;         // Any event this cycle
	logic         ev_inj;     // Event is an injected one
	errfi_class_t ev_class;   // Class of the event
	logic [4:0]   ev_code;    // Code to record
	logic         ev_abort;   // Abort flag to fold in
	logic         ev_av;      // Event address valid
	logic         ev_keep_av; // Leave address state unchanged
	logic         ev_mv;      // Event carries misc syndrome
	logic [DW-1:0] ev_misc;   // Misc word to record

	// Access gating and software clears
	logic          sel_ok;    // Record visible through aliases
	logic          wr_stat;   // Status write this cycle
	logic          wr_addr;   // Address write this cycle
	logic          wr_misc;   // Misc write this cycle
	logic [DW-1:0] w1c;       // Bits software clears
	logic [DW-1:0] status_rd; // Assembled status word

	// Flags after clear, and next values from the merge
	logic       v_c, ue_c, de_c, of_c, er_c, av_c, mv_c;
	logic [1:0] ce_c;
	logic       v_nxt, ue_nxt, de_nxt, of_nxt, er_nxt, av_nxt, mv_nxt;
	logic [1:0] ce_nxt;
	logic       take;         // Event owns the syndrome

	// Two-flop release of the asynchronous reset
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Alias decode; another record number sees nothing here
	always_comb begin
		sel_ok  = (i_record_select == SEL_RECORD0);
		wr_stat = i_reg_wr & sel_ok & (i_reg_id == ERRFI_REG_STAT);
		wr_addr = i_reg_wr & sel_ok & (i_reg_id == ERRFI_REG_ADDR);
		wr_misc = i_reg_wr & sel_ok & (i_reg_id == ERRFI_REG_MISC0);
		w1c     = wr_stat ? i_reg_wdata : WORD_ZERO;
	end

	// Event source choice
	// A natural error takes the cycle; an injection that fires in
	// the same cycle is dropped, since the counter only models one
	// synthetic fault and a real error already updates the record.
	always_comb begin
		ev      = i_err_valid | i_inj_fire;
		ev_inj  = i_inj_fire & !i_err_valid;
		if (ev_inj) begin
			ev_class   = i_inj_class;
			ev_code    = i_inj_tag ? CODE_INJ_TAG : CODE_DATA_ECC;
			ev_abort   = i_inj_abort;
			ev_av      = 1'b0;
			ev_keep_av = 1'b1;
			ev_mv      = 1'b1;
			ev_misc    = {{(DW-8){1'b0}}, INJ_IMPL_CODE};
		end else begin
			ev_class   = i_err_class;
			ev_code    = i_err_code;
			ev_abort   = i_err_abort;
			ev_av      = i_err_av;
			ev_keep_av = 1'b0;
			ev_mv      = i_err_mv;
			ev_misc    = i_err_misc;
		end
	end

	// Software clears act first so a same-cycle event survives them
	always_comb begin
		v_c  = v_r  & !w1c[ST_V];
		ue_c = ue_r & !w1c[ST_UE];
		de_c = de_r & !w1c[ST_DE];
		of_c = of_r & !w1c[ST_OF];
		er_c = er_r & !w1c[ST_ER];
		av_c = av_r & !w1c[ST_AV];
		mv_c = mv_r & !w1c[ST_MV];
		// Writing one to either corrected bit clears the field
		ce_c = (w1c[ST_CE_HI] | w1c[ST_CE_LO]) ? CE_NONE : ce_r;
	end

	// Flag merge for the single event of this cycle
	errfi_merge u_merge (
		.i_ev         (ev),
		.i_ev_class   (ev_class),
		.i_ev_av      (ev_av),
		.i_ev_keep_av (ev_keep_av),
		.i_ev_mv      (ev_mv),
		.i_ev_abort   (ev_abort),
		.i_v          (v_c),
		.i_ue         (ue_c),
		.i_de         (de_c),
		.i_ce         (ce_c),
		.i_of         (of_c),
		.i_er         (er_c),
		.i_av         (av_c),
		.i_mv         (mv_c),
		.o_v          (v_nxt),
		.o_ue         (ue_nxt),
		.o_de         (de_nxt),
		.o_ce         (ce_nxt),
		.o_of         (of_nxt),
		.o_er         (er_nxt),
		.o_av         (av_nxt),
		.o_mv         (mv_nxt),
		.o_take       (take)
	);

	// Status flags; the set wins over a clear in the same cycle
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			v_r  <= 1'b0;
			ue_r <= 1'b0;
			de_r <= 1'b0;
			ce_r <= CE_NONE;
			of_r <= 1'b0;
			er_r <= 1'b0;
			av_r <= 1'b0;
			mv_r <= 1'b0;
		end else begin
			v_r  <= v_nxt;
			ue_r <= ue_nxt;
			de_r <= de_nxt;
			ce_r <= ce_nxt;
			of_r <= of_nxt;
			er_r <= er_nxt;
			av_r <= av_nxt;
			mv_r <= mv_nxt;
		end
	end

	// Primary error code follows the highest-priority error
	// Cleared only by reset; while the valid flag is low its
	// contents mean nothing to software.
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			code_r <= CODE_NONE;
		end else if (take) begin
			code_r <= ev_code;
		end
	end

	// Address register: event with an address, else software
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			addr_r <= WORD_ZERO;
		end else if (take && !ev_keep_av && ev_av) begin
			addr_r <= i_err_addr;
		end else if (wr_addr) begin
			addr_r <= i_reg_wdata;
		end
	end

	// First misc register: event syndrome, else software
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			misc0_r <= WORD_ZERO;
		end else if (take && ev_mv) begin
			misc0_r <= ev_misc;
		end else if (wr_misc) begin
			misc0_r <= i_reg_wdata;
		end
	end

	// Critical mark of injected errors; held at the fixed choice
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			crit_r <= 1'b0;
		end else if (take && ev_inj) begin
			crit_r <= INJ_SETS_CRIT;
		end else if (w1c[ST_V]) begin
			crit_r <= 1'b0;
		end
	end

	// Status word assembly
	always_comb begin
		status_rd             = WORD_ZERO;
		status_rd[ST_AV]      = av_r;
		status_rd[ST_V]       = v_r;
		status_rd[ST_UE]      = ue_r;
		status_rd[ST_ER]      = er_r;
		status_rd[ST_OF]      = of_r;
		status_rd[ST_MV]      = mv_r;
		status_rd[ST_CE_HI:ST_CE_LO] = ce_r;
		status_rd[ST_DE]      = de_r;
		// Poisoned data is indistinguishable from corrupted data
		status_rd[ST_PN]      = PN_VALUE;
		status_rd[ST_UET_HI:ST_UET_LO] = UET_UNCONT;
		status_rd[ST_CODE_HI:ST_CODE_LO] = code_r;
	end

	// Read port: one-cycle latency, zero for a foreign record
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_reg_rdata <= WORD_ZERO;
			o_reg_rack  <= 1'b0;
		end else begin
			o_reg_rack <= i_reg_rd;
			if (!i_reg_rd || !sel_ok) begin
				o_reg_rdata <= WORD_ZERO;
			end else begin
				unique case (i_reg_id)
					// Fixed capability word; writes have no effect
					ERRFI_REG_FEAT:  o_reg_rdata <= FEAT_VALUE;
					ERRFI_REG_STAT:  o_reg_rdata <= status_rd;
					ERRFI_REG_ADDR:  o_reg_rdata <= addr_r;
					ERRFI_REG_MISC0: o_reg_rdata <= misc0_r;
				endcase
			end
		end
	end

	// Recovery interrupt stays up while the uncorrected flag is set
	// Registered, so it follows the flag by one cycle and drops one
	// cycle after software clears the flag.
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_recovery_irq <= 1'b0;
		end else begin
			o_recovery_irq <= i_recovery_irq_en & ue_r;
		end
	end

	// Critical mark presented as a plain output
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_inj_crit <= 1'b0;
		end else begin
			o_inj_crit <= crit_r;
		end
	end

endmodule : errfi_node

// ---- errfi_node_checker.sv ----
// Purpose : Port-level properties of the error record node.
// Assumes : Bound to every errfi_node; one clock, raw async reset.
// Notes   : Register-side, interrupt and critical-mark relations only.
`timescale 1ns/1ns
module errfi_node_checker (
	input wire logic                         i_ref_clk,
	input wire logic                         i_arst_n,
	input wire logic [errfi_pkg::SEL_W-1:0]  i_record_select,
	input wire errfi_pkg::errfi_reg_t        i_reg_id,
	input wire logic                         i_reg_rd,
	input wire logic                         i_reg_wr,
	input wire logic [errfi_pkg::DW-1:0]     o_reg_rdata,
	input wire logic                         o_reg_rack,
	input wire logic                         i_err_valid,
	input wire errfi_pkg::errfi_class_t      i_err_class,
	input wire logic                         i_recovery_irq_en,
	input wire logic                         o_recovery_irq,
	input wire logic                         o_inj_crit
);
	import errfi_pkg::*;
	// Single domain, so clock and reset are given once
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);

	// Read taken while the record is selected
	sequence s_sel_read;
		i_reg_rd && i_record_select == 16'h0000;
	endsequence
	// Uncorrected event, then the enable held one more edge
	sequence s_fatal_armed;
		(i_err_valid && i_err_class == ERRFI_CLS_UE) ##1 i_recovery_irq_en;
	endsequence

	a_read_answered: assert property (i_reg_rd |=> o_reg_rack)
		else $error("read without acknowledge");
	a_no_stray_ack: assert property (o_reg_rack |-> $past(i_reg_rd))
		else $error("acknowledge without read");
	a_quiet_data_zero: assert property (!o_reg_rack |-> o_reg_rdata == 0)
		else $error("read data not zero outside answer");
	a_feat_fixed: assert property ((s_sel_read and
		i_reg_id == ERRFI_REG_FEAT) |=> o_reg_rdata == 32'hC0000062)
		else $error("feature word wrong");
	a_other_sel_zero: assert property ((i_reg_rd &&
		i_record_select != 16'h0000) |=> o_reg_rdata == 32'h00000000)
		else $error("unselected record visible");
	a_stat_fixed_zero: assert property ((s_sel_read and
		i_reg_id == ERRFI_REG_STAT) |=> o_reg_rdata[22:5] == 18'h00000)
		else $error("poison, type or reserved bits set");
	a_crit_stays_low: assert property (!o_inj_crit)
		else $error("critical mark raised");
	a_irq_gated: assert property (o_recovery_irq |-> $past(i_recovery_irq_en))
		else $error("interrupt while disabled");
	a_irq_follows: assert property (s_fatal_armed |=> o_recovery_irq)
		else $error("interrupt missing after uncorrected error");
	a_irq_holds: assert property ((o_recovery_irq && i_recovery_irq_en &&
		!$past(i_reg_wr)) |=> o_recovery_irq)
		else $error("interrupt dropped without a clear");
endmodule : errfi_node_checker

bind errfi_node errfi_node_checker chk_u (
	.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
	.i_record_select(i_record_select), .i_reg_id(i_reg_id),
	.i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .o_reg_rdata(o_reg_rdata),
	.o_reg_rack(o_reg_rack), .i_err_valid(i_err_valid),
	.i_err_class(i_err_class), .i_recovery_irq_en(i_recovery_irq_en),
	.o_recovery_irq(o_recovery_irq), .o_inj_crit(o_inj_crit)
);

// ---- testbench.sv ----
// Purpose : Self-checking bench for the error record node.
// Assumes : 100 MHz clock; inputs driven by NBA at rising edges.
// Notes   : Ordinary events are table rows; special cases follow.
`timescale 1ns/1ns
module testbench;
	import errfi_pkg::*;
	// One table case: stimulus and the status it should leave
	typedef struct {
		logic         nat;  // 1 natural error, 0 injection
		errfi_class_t cls;  // Event class
		logic [4:0]   code; // Natural code; 5 tag or 6 data if injected
		logic         abt;  // Abort signalled
		logic         adr;  // Address known
		logic         msc;  // Misc syndrome present
		logic [31:0]  st;   // Expected status word
	} errfi_row_t;
	localparam logic [31:0] ADDR_A = 32'h12345678; // Fixed fault address
	logic              clk, arst_n, rd, wr, rack, irq, irq_en, crit;
	logic [15:0]       sel;      // Record select
	errfi_reg_t        reg_id;   // Alias picked
	logic [31:0]       wdata, rdata, got;
	logic              err_v, err_abt, err_adr, err_msc;
	errfi_class_t      err_cls, inj_cls;
	logic [4:0]        err_code;
	logic              inj_fire, inj_tag, inj_abt;
	int                fail_count, checks_done;
	errfi_row_t        rows[10];

	errfi_node dut_u (
		.i_ref_clk(clk), .i_arst_n(arst_n), .i_record_select(sel),
		.i_reg_id(reg_id), .i_reg_rd(rd), .i_reg_wr(wr),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rack(rack),
		.i_err_valid(err_v), .i_err_class(err_cls), .i_err_code(err_code),
		.i_err_abort(err_abt), .i_err_av(err_adr), .i_err_addr(ADDR_A),
		.i_err_mv(err_msc), .i_err_misc(32'h0000ABCD),
		.i_inj_fire(inj_fire), .i_inj_class(inj_cls), .i_inj_tag(inj_tag),
		.i_inj_abort(inj_abt), .i_recovery_irq_en(irq_en),
		.o_recovery_irq(irq), .o_inj_crit(crit)
	);

	// Free-running core clock
	always #5 clk = ~clk;

	// Compare and count; four-state equality so unknowns fail
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h want %h", $time, m, g, e);
		end
	endtask : chk

	// One read: strobe a cycle, answer lands after the taking edge
	task automatic rdchk(input errfi_reg_t id, input logic [15:0] s,
		input logic [31:0] e, input string m);
		@(posedge clk);
		reg_id <= id;
		sel <= s;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({31'h0, rack}, 32'h1, "ack");
		chk(rdata, e, m);
	endtask : rdchk

	// One write strobe
	task automatic wrt(input errfi_reg_t id, input logic [15:0] s,
		input logic [31:0] d);
		@(posedge clk);
		reg_id <= id;
		sel <= s;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 0;
	endtask : wrt

	// One error event, natural or injected, one cycle wide
	task automatic ev(input logic n, input errfi_class_t c,
		input logic [4:0] k, input logic ab, input logic ad,
		input logic ms);
		@(posedge clk);
		err_v <= n;
		inj_fire <= ~n;
		err_cls <= c;
		inj_cls <= c;
		err_code <= k;
		inj_tag <= (k == 5'h05);
		err_abt <= ab;
		inj_abt <= ab;
		err_adr <= ad;
		err_msc <= ms;
		@(posedge clk);
		err_v <= 1'b0;
		inj_fire <= 1'b0;
	endtask : ev

	// Prints counts and the verdict, then stops
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// Hang guard: the whole run needs well under 2000 cycles
	initial begin
		repeat (2000) @(posedge clk);
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		rows = '{
			'{1, ERRFI_CLS_CE, 5'h02, 0, 0, 0, 32'h42000002},
			'{1, ERRFI_CLS_DE, 5'h15, 1, 1, 1, 32'hD4800015},
			'{1, ERRFI_CLS_UE, 5'h07, 0, 0, 0, 32'h60000007},
			'{1, ERRFI_CLS_UE, 5'h08, 1, 1, 0, 32'hF0000008},
			'{1, ERRFI_CLS_CE, 5'h12, 0, 0, 0, 32'h42000012},
			'{1, ERRFI_CLS_CE, 5'h01, 0, 0, 0, 32'h42000001},
			'{1, ERRFI_CLS_DE, 5'h06, 0, 0, 0, 32'h40800006},
			'{0, ERRFI_CLS_CE, 5'h05, 0, 0, 0, 32'h46000005},
			'{0, ERRFI_CLS_DE, 5'h06, 1, 0, 0, 32'h54800006},
			'{0, ERRFI_CLS_UE, 5'h06, 0, 0, 0, 32'h64000006}};
		clk = 0;
		arst_n = 0;
		{rd, wr, irq_en, err_v, err_abt, err_adr, err_msc} = '0;
		{inj_fire, inj_tag, inj_abt} = '0;
		{sel, wdata, err_code} = '0;
		reg_id = ERRFI_REG_FEAT;
		err_cls = ERRFI_CLS_CE;
		inj_cls = ERRFI_CLS_CE;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset image, and a write to the read-only word
		rdchk(ERRFI_REG_FEAT, 16'h0, 32'hC0000062, "feat");
		rdchk(ERRFI_REG_STAT, 16'h0, 32'h00000000, "stat");
		rdchk(ERRFI_REG_ADDR, 16'h0, 32'h00000000, "addr");
		wrt(ERRFI_REG_FEAT, 16'h0, 32'h00000000);
		rdchk(ERRFI_REG_FEAT, 16'h0, 32'hC0000062, "feat ro");
		$display("test reset done");
		// Every class and code from a clean record
		for (int i = 0; i < 10; i++) begin
			ev(rows[i].nat, rows[i].cls, rows[i].code, rows[i].abt,
				rows[i].adr, rows[i].msc);
			rdchk(ERRFI_REG_STAT, 16'h0, rows[i].st, "row");
			wrt(ERRFI_REG_STAT, 16'h0, 32'hFFFFFFFF);
		end
		rdchk(ERRFI_REG_MISC0, 16'h0, 32'h00000001, "inj misc");
		$display("test rows done");
		// Unselected record: reads zero, writes ignored
		ev(1, ERRFI_CLS_CE, 5'h02, 0, 1, 1);
		rdchk(ERRFI_REG_STAT, 16'h1, 32'h00000000, "sel rd");
		wrt(ERRFI_REG_STAT, 16'h1, 32'hFFFFFFFF);
		rdchk(ERRFI_REG_STAT, 16'h0, 32'hC6000002, "sel wr");
		rdchk(ERRFI_REG_MISC0, 16'h0, 32'h0000ABCD, "nat misc");
		// Injection takes over but leaves the address alone
		ev(0, ERRFI_CLS_UE, 5'h06, 0, 0, 0);
		rdchk(ERRFI_REG_STAT, 16'h0, 32'hE6000006, "inj av");
		rdchk(ERRFI_REG_ADDR, 16'h0, ADDR_A, "inj addr");
		rdchk(ERRFI_REG_MISC0, 16'h0, 32'h00000001, "inj misc2");
		chk({31'h0, crit}, 32'h0, "crit");
		wrt(ERRFI_REG_STAT, 16'h0, 32'hFFFFFFFF);
		$display("test select done");
		// Same rank overflows, higher rank replaces and clears it
		ev(1, ERRFI_CLS_CE, 5'h02, 0, 0, 0);
		ev(1, ERRFI_CLS_CE, 5'h06, 0, 0, 0);
		rdchk(ERRFI_REG_STAT, 16'h0, 32'h4A000002, "of ce");
		ev(1, ERRFI_CLS_UE, 5'h07, 0, 1, 0);
		rdchk(ERRFI_REG_STAT, 16'h0, 32'hE2000007, "of ue");
		ev(0, ERRFI_CLS_UE, 5'h05, 0, 0, 0);
		rdchk(ERRFI_REG_STAT, 16'h0, 32'hEA000007, "of inj");
		wrt(ERRFI_REG_STAT, 16'h0, 32'hFFFFFFFF);
		$display("test overflow done");
		// Interrupt masked, then enabled, then cleared
		ev(1, ERRFI_CLS_UE, 5'h08, 1, 0, 0);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0, "irq masked");
		@(posedge clk);
		irq_en <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h1, "irq on");
		wrt(ERRFI_REG_STAT, 16'h0, 32'h20000000);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0, "irq off");
		// Enabled uncorrected error raises the line next cycle
		ev(1, ERRFI_CLS_UE, 5'h07, 0, 0, 0);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h1, "irq live");
		$display("test irq done");
		// Software address write, wiped by the later reset
		wrt(ERRFI_REG_ADDR, 16'h0, 32'h0000BEEF);
		rdchk(ERRFI_REG_ADDR, 16'h0, 32'h0000BEEF, "addr wr");
		// Reset again in mid-run; record must read clean
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk(ERRFI_REG_STAT, 16'h0, 32'h00000000, "rst2");
		rdchk(ERRFI_REG_ADDR, 16'h0, 32'h00000000, "addr rst2");
		chk({31'h0, irq}, 32'h0, "irq rst2");
		$display("test rereset done");
		summarize();
	end
endmodule : testbench
